/* common/psar_pkg.sv */
// Package with addresses, widths, reset values and carrier types of the shared-address port block
package psar_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    // Byte addresses of the internal register interface
    localparam logic [15:0] ADDR_TIMER = 16'hffb3;
    localparam logic [15:0] ADDR_PORT_DATA = 16'hffd6;
    localparam logic [15:0] ADDR_PORT_DIR = 16'hffe6;
    // Reset and fixed read values
    localparam logic [7:0] DIR_READ_VALUE = 8'hff;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] LOAD_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Byte request from the CPU core
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } psar_req_s;

    // Read-modify-write sequencer states, Gray order
    typedef enum logic [1:0] {
        PSAR_IDLE = 2'b00,
        PSAR_READ = 2'b01,
        PSAR_WRITE = 2'b11
    } psar_rmw_e;
endpackage : psar_pkg

/* design/psar_sync.sv */
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module psar_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // All state in one struct
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } psar_sync_s;

    psar_sync_s st;
    psar_sync_s next_st;

    // First stage is read only by the second stage
    always_comb begin
        next_st = st;
        if (ce) begin
            next_st.meta = async_in;
            next_st.stable = st.meta;
        end
    end

    // Register the state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stable;
endmodule : psar_sync

/* design/psar_top.sv */
// Shared-address readback: free-running timer counter/load and port data/direction byte registers
// Functional notes
// - A read of the shared timer address returns the running counter, not the load value.
// - A write to the shared timer address stores the byte into the load register only.
// - The counter runs on its own, so a read-modify-write there may copy counter bits into load.
// - A bit set or clear reads one byte, changes only the named bit, and writes it all back.
// - A port data read returns the sampled pin level for every input pin bit.
// - A port data read returns the output latch bit for every output pin bit.
// - A port data write loads every latch bit, and each output pin drives its latch bit.
// - The direction register is write-only and always reads as all ones.
// - A direction bit of zero makes the pin an input, one makes it an output from the latch.
`timescale 1ns/1ps
module psar_top #(
    parameter int PORT_W = 8
) (
    // Clock, reset and enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Byte access from the core
    input wire psar_pkg::psar_req_s req,
    // Bit instruction start
    input wire logic bit_set_instruction,
    input wire logic bit_clear_instruction,
    input wire logic [2:0] bit_index,
    input wire logic [15:0] bit_addr,
    // Timer tick and pin levels
    input wire logic count_tick,
    input wire logic [PORT_W-1:0] pin_in,
    // Read return and sequencer status
    output logic [7:0] rdata,
    output logic rvalid,
    output logic rmw_busy,
    output logic rmw_done,
    // Pins and timer state
    output logic [PORT_W-1:0] pin_out,
    output logic [PORT_W-1:0] pin_oe,
    output logic [7:0] timer_count,
    output logic [7:0] timer_load
);
    // ==========================================================
    // State
    typedef struct packed {
        // Timer counter and its load register behind one address
        logic [7:0] count;
        logic [7:0] load;
        // Port latch and direction bits
        logic [PORT_W-1:0] port_output_latch;
        logic [PORT_W-1:0] port_direction_control;
        // Read return
        logic [7:0] rdata;
        logic rvalid;
        // Bit instruction sequencer
        psar_pkg::psar_rmw_e rmw;
        logic rmw_busy;
        logic rmw_set;
        logic [2:0] rmw_bit;
        logic [15:0] rmw_addr;
        logic [7:0] rmw_data;
        logic rmw_done;
    } psar_top_s;

    // Registered state, its next value and the synchronised pins
    psar_top_s st;
    psar_top_s next_st;
    logic [PORT_W-1:0] pin_sync;

    // ==========================================================
    // Pin synchroniser
    psar_sync #(
        .WIDTH(PORT_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // ==========================================================
    // Per-pin read view: pin level for inputs, latch bit for outputs
    wire logic [PORT_W-1:0] port_view;
    for (genvar gi = 0; gi < PORT_W; gi++) begin : g_view
        assign port_view[gi] = st.port_direction_control[gi]
            ? st.port_output_latch[gi]
            : pin_sync[gi];
    end

    // ==========================================================
    // Address decode
    typedef enum logic [1:0] {
        PSAR_SEL_NONE = 2'b00,
        PSAR_SEL_TIMER = 2'b01,
        PSAR_SEL_PORT = 2'b11,
        PSAR_SEL_DIR = 2'b10
    } psar_sel_e;

    // Register reached by a byte address; unmapped addresses reach none
    function automatic psar_sel_e decode(input logic [15:0] a);
        if (a == psar_pkg::ADDR_TIMER) begin
            decode = PSAR_SEL_TIMER;
        end else if (a == psar_pkg::ADDR_PORT_DATA) begin
            decode = PSAR_SEL_PORT;
        end else if (a == psar_pkg::ADDR_PORT_DIR) begin
            decode = PSAR_SEL_DIR;
        end else begin
            decode = PSAR_SEL_NONE;
        end
    endfunction : decode

    // Request and sequencer addresses decoded once per cycle
    psar_sel_e req_sel;
    psar_sel_e rmw_sel;
    always_comb begin
        req_sel = decode(req.addr);
        rmw_sel = decode(st.rmw_addr);
    end

    // ==========================================================
    // Byte access
    // Byte read value for a decoded register
    function automatic logic [7:0] read_byte(input psar_top_s s, input psar_sel_e sel,
                                             input logic [PORT_W-1:0] view);
        if (sel == PSAR_SEL_TIMER) begin
            read_byte = s.count;
        end else if (sel == PSAR_SEL_PORT) begin
            read_byte = 8'(view);
        end else if (sel == PSAR_SEL_DIR) begin
            read_byte = psar_pkg::DIR_READ_VALUE;
        end else begin
            read_byte = psar_pkg::UNMAPPED_READ;
        end
    endfunction : read_byte

    // Byte write effect on a decoded register
    function automatic psar_top_s write_byte(input psar_top_s s, input psar_sel_e sel,
                                             input logic [7:0] d);
        // Unmapped addresses change nothing
        write_byte = s;
        if (sel == PSAR_SEL_TIMER) begin
            write_byte.load = d;
        end else if (sel == PSAR_SEL_PORT) begin
            write_byte.port_output_latch = PORT_W'(d);
        end else if (sel == PSAR_SEL_DIR) begin
            write_byte.port_direction_control = PORT_W'(d);
        end
    endfunction : write_byte

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_st = st;
        if (ce) begin
            // Read and done pulses last one cycle
            next_st.rvalid = 1'b0;
            next_st.rmw_done = 1'b0;
            // Free-running counter, independent of the load register
            if (count_tick) begin
                next_st.count = st.count + 8'h01;
            end
            case (st.rmw)
                psar_pkg::PSAR_IDLE: begin
                    // Bit instructions win over reads, reads over writes
                    if (bit_set_instruction || bit_clear_instruction) begin
                        next_st.rmw = psar_pkg::PSAR_READ;
                        next_st.rmw_set = bit_set_instruction;
                        next_st.rmw_bit = bit_index;
                        next_st.rmw_addr = bit_addr;
                    end else if (req.rd) begin
                        next_st.rdata = read_byte(st, req_sel, port_view);
                        next_st.rvalid = 1'b1;
                    end else if (req.wr) begin
                        next_st = write_byte(next_st, req_sel, req.wdata);
                    end
                end
                psar_pkg::PSAR_READ: begin
                    // Read whole byte, then alter only the named bit
                    next_st.rmw_data = read_byte(st, rmw_sel, port_view);
                    next_st.rmw_data[st.rmw_bit] = st.rmw_set;
                    next_st.rmw = psar_pkg::PSAR_WRITE;
                end
                psar_pkg::PSAR_WRITE: begin
                    // Whole altered byte goes back to the same address
                    next_st = write_byte(next_st, rmw_sel, st.rmw_data);
                    next_st.rmw_done = 1'b1;
                    next_st.rmw = psar_pkg::PSAR_IDLE;
                end
                default: begin
                    // Unused code falls back to idle
                    next_st.rmw = psar_pkg::PSAR_IDLE;
                end
            endcase
            // Busy flag registered alongside the sequencer state
            next_st.rmw_busy = (next_st.rmw != psar_pkg::PSAR_IDLE);
        end
    end

    // Register the state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // Clear everything, then apply the named reset values
            st <= '0;
            st.count <= psar_pkg::COUNT_RESET;
            st.load <= psar_pkg::LOAD_RESET;
            st.port_output_latch <= PORT_W'(psar_pkg::LATCH_RESET);
            st.port_direction_control <= PORT_W'(psar_pkg::DIR_RESET);
            st.rmw <= psar_pkg::PSAR_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs, all from flip-flops
    assign rdata = st.rdata;
    assign rvalid = st.rvalid;
    assign rmw_busy = st.rmw_busy;
    assign rmw_done = st.rmw_done;
    assign pin_out = st.port_output_latch;
    assign pin_oe = st.port_direction_control;
    assign timer_count = st.count;
    assign timer_load = st.load;
endmodule : psar_top

/* sim/psar_monitor.sv */
// Checker on the top ports of the shared-address block
`timescale 1ns/1ps
module psar_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire psar_pkg::psar_req_s req,
    input wire logic bit_set_instruction,
    input wire logic bit_clear_instruction,
    input wire logic count_tick,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic rmw_busy,
    input wire logic rmw_done,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] timer_count,
    input wire logic [7:0] timer_load
);
    // ========================================
    // Properties
    wire logic bop = ce && !rmw_busy && (bit_set_instruction || bit_clear_instruction);
    wire logic rd = ce && !rmw_busy && !bop && req.rd;
    wire logic wr = ce && !rmw_busy && !bop && req.wr && !req.rd;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    rd_count_a: assert property (rd && req.addr == psar_pkg::ADDR_TIMER |=>
        rvalid && rdata == $past(timer_count)) else $error("timer read");
    wr_load_a: assert property (wr && req.addr == psar_pkg::ADDR_TIMER |=>
        timer_load == $past(req.wdata)) else $error("timer load write");
    count_run_a: assert property (ce |=>
        timer_count == $past(timer_count) + 8'($past(count_tick))) else $error("count");
    rmw_walk_a: assert property (bop |=> rmw_busy [*2] ##1 (rmw_done && !rmw_busy))
        else $error("bit op sequence");
    port_rd_a: assert property (rd && req.addr == psar_pkg::ADDR_PORT_DATA |=> rvalid &&
        (rdata & $past(pin_oe)) == ($past(pin_out) & $past(pin_oe))) else $error("port read");
    latch_wr_a: assert property (wr && req.addr == psar_pkg::ADDR_PORT_DATA |=>
        pin_out == $past(req.wdata)) else $error("latch write");
    dir_ones_a: assert property (rd && req.addr == psar_pkg::ADDR_PORT_DIR |=>
        rdata == psar_pkg::DIR_READ_VALUE) else $error("direction read");
    dir_wr_a: assert property (wr && req.addr == psar_pkg::ADDR_PORT_DIR |=>
        pin_oe == $past(req.wdata)) else $error("direction write");
    // Main scenarios reached
    cover property (rmw_done);
    cover property (rvalid && rdata == psar_pkg::DIR_READ_VALUE);
    cover property (count_tick [*2]);
    cover property (!ce ##1 ce);
endmodule : psar_monitor

bind psar_top psar_monitor mon (.clk_sys, .rst_n, .ce, .req, .bit_set_instruction,
    .bit_clear_instruction, .count_tick, .rdata, .rvalid, .rmw_busy, .rmw_done,
    .pin_out, .pin_oe, .timer_count, .timer_load);

/* sim/psar_cpu_model.sv */
// Model of the CPU core issuing byte accesses and bit instructions
`timescale 1ns/1ps
module psar_cpu_model (
    input wire logic clk_sys,
    output psar_pkg::psar_req_s req,
    output logic bit_set_instruction,
    output logic bit_clear_instruction,
    output logic [2:0] bit_index,
    output logic [15:0] bit_addr
);
    // ========================================
    // Requests
    initial {req, bit_set_instruction, bit_clear_instruction, bit_index, bit_addr} = '0;
    // One request cycle, k is rd wr set clear; address and data turn over once released
    task automatic acc(input logic [3:0] k, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        {req.rd, req.wr, bit_set_instruction, bit_clear_instruction} <= k;
        {req.addr, req.wdata, bit_addr, bit_index} <= {a, d, a, d[2:0]};
        @(negedge clk_sys);
        {req.rd, req.wr, bit_set_instruction, bit_clear_instruction} <= 4'h0;
        {req.addr, req.wdata, bit_addr, bit_index} <= ~{a, d, a, d[2:0]};
        if (k[1:0] != 2'b00) repeat (3) @(negedge clk_sys);
    endtask : acc
endmodule : psar_cpu_model

/* sim/psar_top_tb.sv */
// Self-checking bench of the shared-address port block
`timescale 1ns/1ps
module psar_top_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic count_tick = 1'b0;
    logic [7:0] pin_in = 8'h00;
    psar_pkg::psar_req_s req;
    logic bit_set_instruction, bit_clear_instruction, rvalid, rmw_busy, rmw_done;
    logic [2:0] bit_index;
    logic [15:0] bit_addr;
    logic [7:0] rdata, pin_out, pin_oe, timer_count, timer_load;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    // ========================================
    // Partner, design, clock and hang guard
    psar_cpu_model cpu (.clk_sys, .req, .bit_set_instruction, .bit_clear_instruction,
        .bit_index, .bit_addr);
    psar_top dut (.clk_sys, .rst_n, .ce, .req, .bit_set_instruction, .bit_clear_instruction,
        .bit_index, .bit_addr, .count_tick, .pin_in, .rdata, .rvalid, .rmw_busy, .rmw_done,
        .pin_out, .pin_oe, .timer_count, .timer_load);
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // Compare one byte
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic report_and_stop();
        if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    // Pins 7 and 6 inputs, latch 80, then direction reads as ones
    task automatic t_dir();
        cpu.acc(4'h4, psar_pkg::ADDR_PORT_DIR, 8'h3f);
        cpu.acc(4'h4, psar_pkg::ADDR_PORT_DATA, 8'h80);
        chk("pin_oe", pin_oe, 8'h3f);
        chk("pin_out", pin_out, 8'h80);
        cpu.acc(4'h8, psar_pkg::ADDR_PORT_DIR, 8'h00);
        chk("dir read", rdata, psar_pkg::DIR_READ_VALUE);
    endtask : t_dir
    // Mixed read gives pins and latch; bit set copies pin levels into the latch
    task automatic t_port();
        pin_in <= 8'h7f;
        repeat (3) @(negedge clk_sys);
        cpu.acc(4'h8, psar_pkg::ADDR_PORT_DATA, 8'h00);
        chk("port read", rdata, (8'h3f & 8'h80) | (~8'h3f & 8'h7f));
        cpu.acc(4'h2, psar_pkg::ADDR_PORT_DATA, 8'h00);
        chk("port bit set", pin_out, 8'h41);
    endtask : t_port
    // Twenty ticks, load write, count read, bit clear copies count into load
    task automatic t_timer();
        count_tick <= 1'b1;
        repeat (20) @(negedge clk_sys);
        count_tick <= 1'b0;
        cpu.acc(4'h4, psar_pkg::ADDR_TIMER, 8'h5a);
        chk("load", timer_load, 8'h5a);
        cpu.acc(4'h8, psar_pkg::ADDR_TIMER, 8'h00);
        chk("count read", rdata, 8'h14);
        cpu.acc(4'h1, psar_pkg::ADDR_TIMER, 8'h02);
        chk("load after clear", timer_load, 8'h10);
        cpu.acc(4'h1, psar_pkg::ADDR_PORT_DIR, 8'h00);
        chk("dir after clear", pin_oe, 8'hfe);
    endtask : t_timer
    // Enable low freezes counter and latch although ticks and a write are offered
    task automatic t_freeze();
        ce <= 1'b0;
        count_tick <= 1'b1;
        cpu.acc(4'h4, psar_pkg::ADDR_PORT_DATA, 8'h00);
        chk("frozen count", timer_count, 8'h14);
        chk("frozen latch", pin_out, 8'h41);
        count_tick <= 1'b0;
        ce <= 1'b1;
    endtask : t_freeze
    initial begin
        repeat (8) @(negedge clk_sys);
        rst_n <= 1'b1;
        t_dir();
        t_port();
        t_timer();
        t_freeze();
        report_and_stop();
    end
endmodule : psar_top_tb
